// file: logic/cse_pkg.sv
// Constants and types for the shift, logic and branch execute block
package cse_pkg;
  // Instruction patterns and their masks
  localparam logic [15:0] MASK_NM    = 16'hF00F;
  localparam logic [15:0] MASK_HI8   = 16'hFF00;
  localparam logic [15:0] MASK_HI4   = 16'hF000;
  localparam logic [15:0] MASK_REG   = 16'hF0FF;
  localparam logic [15:0] MASK_ALL   = 16'hFFFF;
  localparam logic [15:0] OP_SUB_BOR = 16'h300A;
  localparam logic [15:0] OP_SUB_OVF = 16'h300B;
  localparam logic [15:0] OP_MTEST   = 16'h2008;
  localparam logic [15:0] OP_MEM_MASK = 16'hCC00;
  localparam logic [15:0] OP_MEM_AND = 16'hCD00;
  localparam logic [15:0] OP_MEM_XOR = 16'hCE00;
  localparam logic [15:0] OP_MEM_OR  = 16'hCF00;
  localparam logic [15:0] OP_IMM_AND = 16'hC900;
  localparam logic [15:0] OP_IMM_XOR = 16'hCA00;
  localparam logic [15:0] OP_IMM_OR  = 16'hCB00;
  localparam logic [15:0] OP_ATS     = 16'h401B;
  localparam logic [15:0] OP_ROT_L   = 16'h4004;
  localparam logic [15:0] OP_ROT_R   = 16'h4005;
  localparam logic [15:0] OP_ROTF_L  = 16'h4024;
  localparam logic [15:0] OP_ROTF_R  = 16'h4025;
  localparam logic [15:0] OP_ASH_L   = 16'h4020;
  localparam logic [15:0] OP_ASH_R   = 16'h4021;
  localparam logic [15:0] OP_LSH_L   = 16'h4000;
  localparam logic [15:0] OP_LSH_R   = 16'h4001;
  localparam logic [15:0] OP_LSH_L2  = 16'h4008;
  localparam logic [15:0] OP_LSH_R2  = 16'h4009;
  localparam logic [15:0] OP_LSH_L8  = 16'h4018;
  localparam logic [15:0] OP_LSH_R8  = 16'h4019;
  localparam logic [15:0] OP_LSH_L16 = 16'h4028;
  localparam logic [15:0] OP_LSH_R16 = 16'h4029;
  localparam logic [15:0] OP_BR_SET  = 16'h8900;
  localparam logic [15:0] OP_BR_CLR  = 16'h8B00;
  localparam logic [15:0] OP_DBR_SET = 16'h8D00;
  localparam logic [15:0] OP_DBR_CLR = 16'h8F00;
  localparam logic [15:0] OP_RJUMP   = 16'hA000;
  localparam logic [15:0] OP_RCALL   = 16'hB000;
  localparam logic [15:0] OP_RRJUMP  = 16'h0023;
  localparam logic [15:0] OP_RRCALL  = 16'h0003;
  localparam logic [15:0] OP_AJUMP   = 16'h402B;
  localparam logic [15:0] OP_ACALL   = 16'h400B;
  localparam logic [15:0] OP_RETURN  = 16'h000B;
  // Reset values and cycle counts
  localparam logic [31:0] PC_RESET      = 32'h0000_0000;
  localparam logic [31:0] PC_STEP       = 32'h0000_0002;
  localparam logic [31:0] PC_AHEAD      = 32'h0000_0004;
  localparam logic [1:0]  STALL_TAKEN   = 2'h2;
  localparam logic [1:0]  STALL_DELAYED = 2'h1;
  localparam logic [1:0]  STALL_TEST    = 2'h1;
  localparam logic [7:0]  ATS_MARK      = 8'h80;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } cse_bus_req_type;

  typedef struct packed {
    logic       ready;
    logic [7:0] rdata;
  } cse_bus_rsp_type;

  typedef enum logic [2:0] {ST_EXEC, ST_STALL, ST_READ, ST_HOLD, ST_WRITE} cse_state_type;
endpackage

// file: logic/cse_exec.sv
// Execute unit for subtract, logic, shift and branch instructions
// Operation
// - Borrowing subtract: dest minus source minus flag, borrow into flag, one cycle.
// - Overflow subtract: dest minus source, flag set on signed overflow or underflow.
// - Register mask test: AND two registers, flag set when result is zero.
// - Memory mask test: byte at r0 plus base AND immediate, zero sets flag.
// - Memory byte AND, OR, XOR: read, combine, write back, flag kept.
// - Immediate AND, OR, XOR on r0 with zero-extended byte, flag kept.
// - Atomic test-set: flag set if byte zero, write back with top bit set.
// - No DMA or transfer-controller cycles between atomic read and write.
// - External bus request is still granted between atomic read and write.
// - Plain rotates move one bit; the bit moved round also goes to flag.
// - Rotates through flag insert old flag and load the bit shifted out.
// - Single left shifts fill zero and load old top bit into flag.
// - Single right shifts load old bit 0 into flag; arithmetic keeps sign.
// - Multi-bit logical shifts by 2, 8 or 16 with zero fill, flag kept.
// - Conditional branches on flag clear or set; taken 3 cycles, untaken 1.
// - Delayed conditional branches run the slot first; taken 2 cycles, untaken 1.
// - Relative jump with 12-bit displacement, delayed, 2 cycles.
// - Register-relative jump to PC plus register, delayed, 2 cycles.
// - Relative call saves PC to link register, delayed jump, 2 cycles.
// - Register-relative and absolute calls save PC to link, delayed, 2 cycles.
// - Absolute jump loads PC from a register, link untouched, delayed, 2 cycles.
// - Return loads PC from the link register, delayed, 2 cycles.
`timescale 1ns/1ps
module cse_exec (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     instr_valid,
  input  wire logic [15:0]              instr,
  output logic                          instr_ready_r,
  input  wire logic [31:0]              global_base_reg,
  input  wire logic                     rf_load_en,
  input  wire logic [3:0]               rf_load_idx,
  input  wire logic [31:0]              rf_load_data,
  output cse_pkg::cse_bus_req_type      bus_req_r,
  input  wire cse_pkg::cse_bus_rsp_type bus_rsp,
  output logic                          dma_block_r,
  input  wire logic                     external_bus_request,
  output logic                          ext_grant_r,
  output logic [31:0]                   pc_r,
  output logic                          t_flag_r,
  output logic [31:0]                   return_link_reg_r
);
  import cse_pkg::*;

  // ==========================================================
  // Decode
  logic        acc;
  logic [31:0] rn_w;
  logic [31:0] rm_w;
  logic [31:0] r0_w;
  logic [32:0] sub_w;
  logic [31:0] dif_w;
  logic        borrow_w;
  logic        ovf_w;
  logic        and_zero_w;
  logic [31:0] pc4_w;
  logic [31:0] d8_w;
  logic [31:0] d12_w;
  logic [31:0] mem_addr_w;
  logic [31:0] rf_r [16];
  logic [31:0] rf_nxt [16];

  assign acc        = instr_valid && instr_ready_r;
  assign rn_w       = rf_r[instr[11:8]];
  assign rm_w       = rf_r[instr[7:4]];
  assign r0_w       = rf_r[0];
  assign sub_w      = {1'b0, rn_w} - {1'b0, rm_w} - {32'h0, t_flag_r};
  assign borrow_w   = sub_w[32];
  assign dif_w      = rn_w - rm_w;
  assign ovf_w      = (rn_w[31] != rm_w[31]) && (dif_w[31] != rn_w[31]);
  assign and_zero_w = (rn_w & rm_w) == 32'h0;
  assign pc4_w      = pc_r + PC_AHEAD;
  assign d8_w       = {{23{instr[7]}}, instr[7:0], 1'b0};
  assign d12_w      = {{19{instr[11]}}, instr[11:0], 1'b0};
  assign mem_addr_w = r0_w + global_base_reg;

  logic is_sub_bor, is_sub_ovf, is_mtest, is_mem_mask, is_mem_op, is_imm_op, is_ats;
  logic is_bcc, is_dbcc, is_multi, is_rot_l, is_rcall, taken_w;
  assign is_sub_bor = (instr & MASK_NM) == OP_SUB_BOR;
  assign is_sub_ovf = (instr & MASK_NM) == OP_SUB_OVF;
  assign is_mtest   = (instr & MASK_NM) == OP_MTEST;
  assign is_mem_mask = (instr & MASK_HI8) == OP_MEM_MASK;
  assign is_mem_op  = (instr & MASK_HI8) == OP_MEM_AND || (instr & MASK_HI8) == OP_MEM_OR
                      || (instr & MASK_HI8) == OP_MEM_XOR;
  assign is_imm_op  = (instr & MASK_HI8) == OP_IMM_AND || (instr & MASK_HI8) == OP_IMM_OR
                      || (instr & MASK_HI8) == OP_IMM_XOR;
  assign is_ats     = (instr & MASK_REG) == OP_ATS;
  assign is_bcc     = (instr & MASK_HI8) == OP_BR_SET || (instr & MASK_HI8) == OP_BR_CLR;
  assign is_dbcc    = (instr & MASK_HI8) == OP_DBR_SET || (instr & MASK_HI8) == OP_DBR_CLR;
  assign is_rot_l   = (instr & MASK_REG) == OP_ROT_L;
  assign is_rcall   = (instr & MASK_HI4) == OP_RCALL;
  assign is_multi   = (instr & MASK_REG) == OP_LSH_L2 || (instr & MASK_REG) == OP_LSH_R2
                      || (instr & MASK_REG) == OP_LSH_L8 || (instr & MASK_REG) == OP_LSH_R8
                      || (instr & MASK_REG) == OP_LSH_L16 || (instr & MASK_REG) == OP_LSH_R16;
  // Set-forms have bit 9 clear
  assign taken_w    = instr[9] ? !t_flag_r : t_flag_r;

  // ==========================================================
  // Next state
  cse_state_type   st_r, st_nxt;
  logic [1:0]      cnt_r, cnt_nxt;
  logic            ats_r, ats_nxt;
  logic [15:0]     op_r, op_nxt;
  logic            dly_pend_r, dly_pend_nxt;
  logic [31:0]     dly_target_r, dly_target_nxt;
  logic [31:0]     pc_nxt, link_nxt;
  logic            t_nxt, ready_nxt, block_nxt, grant_nxt;
  cse_bus_req_type req_nxt;
  logic            ext_meta_r, ext_sync_r;

  always_comb begin
    st_nxt         = st_r;
    cnt_nxt        = cnt_r;
    ats_nxt        = ats_r;
    op_nxt         = op_r;
    dly_pend_nxt   = dly_pend_r;
    dly_target_nxt = dly_target_r;
    pc_nxt         = pc_r;
    link_nxt       = return_link_reg_r;
    t_nxt          = t_flag_r;
    block_nxt      = dma_block_r;
    grant_nxt      = 1'b0;
    req_nxt        = bus_req_r;
    rf_nxt         = rf_r;
    if (rf_load_en) begin
      rf_nxt[rf_load_idx] = rf_load_data;
    end
    case (st_r)
      ST_EXEC: begin
        if (acc) begin
          pc_nxt       = pc_r + PC_STEP;
          op_nxt       = instr;
          dly_pend_nxt = 1'b0;
          if (dly_pend_r) begin
            pc_nxt = dly_target_r;
          end
          if (is_sub_bor) begin
            rf_nxt[instr[11:8]] = sub_w[31:0];
            t_nxt = borrow_w;
          end else if (is_sub_ovf) begin
            rf_nxt[instr[11:8]] = dif_w;
            t_nxt = ovf_w;
          end else if (is_mtest) begin
            t_nxt = and_zero_w;
          end else if (is_mem_mask || is_mem_op || is_ats) begin
            req_nxt.valid = 1'b1;
            req_nxt.write = 1'b0;
            req_nxt.addr  = is_ats ? rn_w : mem_addr_w;
            ats_nxt       = is_ats;
            block_nxt     = is_ats;
            st_nxt        = ST_READ;
          end else if (is_imm_op) begin
            case (instr[9:8])
              2'h1:    rf_nxt[0] = r0_w & {24'h0, instr[7:0]};
              2'h2:    rf_nxt[0] = r0_w ^ {24'h0, instr[7:0]};
              default: rf_nxt[0] = r0_w | {24'h0, instr[7:0]};
            endcase
          end else if (is_multi || (instr & MASK_REG) == OP_LSH_L || (instr & MASK_REG) == OP_LSH_R
                       || (instr & MASK_REG) == OP_ASH_L || (instr & MASK_REG) == OP_ASH_R) begin
            case (instr[5:0])
              6'h00, 6'h20: rf_nxt[instr[11:8]] = {rn_w[30:0], 1'b0};
              6'h01:        rf_nxt[instr[11:8]] = {1'b0, rn_w[31:1]};
              6'h21:        rf_nxt[instr[11:8]] = {rn_w[31], rn_w[31:1]};
              6'h08:        rf_nxt[instr[11:8]] = {rn_w[29:0], 2'h0};
              6'h09:        rf_nxt[instr[11:8]] = {2'h0, rn_w[31:2]};
              6'h18:        rf_nxt[instr[11:8]] = {rn_w[23:0], 8'h0};
              6'h19:        rf_nxt[instr[11:8]] = {8'h0, rn_w[31:8]};
              6'h28:        rf_nxt[instr[11:8]] = {rn_w[15:0], 16'h0};
              6'h29:        rf_nxt[instr[11:8]] = {16'h0, rn_w[31:16]};
              default:      rf_nxt[instr[11:8]] = rn_w;
            endcase
            if (!instr[3]) begin
              t_nxt = instr[0] ? rn_w[0] : rn_w[31];
            end
          end else if ((instr & MASK_REG) == OP_ROT_L || (instr & MASK_REG) == OP_ROT_R
                       || (instr & MASK_REG) == OP_ROTF_L || (instr & MASK_REG) == OP_ROTF_R) begin
            case ({instr[5], instr[0]})
              2'h0:    rf_nxt[instr[11:8]] = {rn_w[30:0], rn_w[31]};
              2'h1:    rf_nxt[instr[11:8]] = {rn_w[0], rn_w[31:1]};
              2'h2:    rf_nxt[instr[11:8]] = {rn_w[30:0], t_flag_r};
              default: rf_nxt[instr[11:8]] = {t_flag_r, rn_w[31:1]};
            endcase
            t_nxt = instr[0] ? rn_w[0] : rn_w[31];
          end else if (is_bcc && !dly_pend_r) begin
            if (taken_w) begin
              pc_nxt  = pc4_w + d8_w;
              cnt_nxt = STALL_TAKEN;
              st_nxt  = ST_STALL;
            end
          end else if (!dly_pend_r && (is_dbcc || (instr & MASK_HI4) == OP_RJUMP || is_rcall
                       || (instr & MASK_REG) == OP_RRJUMP || (instr & MASK_REG) == OP_RRCALL
                       || (instr & MASK_REG) == OP_AJUMP || (instr & MASK_REG) == OP_ACALL
                       || instr == OP_RETURN)) begin
            dly_pend_nxt = !is_dbcc || taken_w;
            cnt_nxt      = STALL_DELAYED;
            st_nxt       = dly_pend_nxt ? ST_STALL : ST_EXEC;
            if (is_dbcc) begin
              dly_target_nxt = pc4_w + d8_w;
            end else if ((instr & MASK_HI4) == OP_RJUMP || is_rcall) begin
              dly_target_nxt = pc4_w + d12_w;
            end else if ((instr & MASK_REG) == OP_RRJUMP || (instr & MASK_REG) == OP_RRCALL) begin
              dly_target_nxt = pc4_w + rn_w;
            end else if (instr == OP_RETURN) begin
              dly_target_nxt = return_link_reg_r;
            end else begin
              dly_target_nxt = rn_w;
            end
            if (is_rcall || (instr & MASK_REG) == OP_RRCALL || (instr & MASK_REG) == OP_ACALL) begin
              link_nxt = pc4_w;
            end
          end
        end
      end
      ST_STALL: begin
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          st_nxt = ST_EXEC;
        end
      end
      ST_READ: begin
        if (bus_rsp.ready) begin
          req_nxt.valid = 1'b0;
          if (ats_r) begin
            t_nxt         = bus_rsp.rdata == 8'h0;
            req_nxt.wdata = bus_rsp.rdata | ATS_MARK;
            st_nxt        = ST_HOLD;
          end else if ((op_r & MASK_HI8) == OP_MEM_MASK) begin
            t_nxt   = (bus_rsp.rdata & op_r[7:0]) == 8'h0;
            cnt_nxt = STALL_TEST;
            st_nxt  = ST_STALL;
          end else begin
            req_nxt.valid = 1'b1;
            req_nxt.write = 1'b1;
            case (op_r[9:8])
              2'h1:    req_nxt.wdata = bus_rsp.rdata & op_r[7:0];
              2'h2:    req_nxt.wdata = bus_rsp.rdata ^ op_r[7:0];
              default: req_nxt.wdata = bus_rsp.rdata | op_r[7:0];
            endcase
            st_nxt = ST_WRITE;
          end
        end
      end
      ST_HOLD: begin
        if (ext_sync_r) begin
          grant_nxt = 1'b1;
        end else begin
          req_nxt.valid = 1'b1;
          req_nxt.write = 1'b1;
          st_nxt        = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (bus_rsp.ready) begin
          req_nxt.valid = 1'b0;
          req_nxt.write = 1'b0;
          block_nxt     = 1'b0;
          st_nxt        = ST_EXEC;
        end
      end
      default: st_nxt = ST_EXEC;
    endcase
    ready_nxt = (st_nxt == ST_EXEC);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    ext_meta_r <= external_bus_request;
    ext_sync_r <= ext_meta_r;
    if (!rst_n) begin
      st_r              <= ST_EXEC;
      cnt_r             <= 2'h0;
      ats_r             <= 1'b0;
      op_r              <= 16'h0;
      dly_pend_r        <= 1'b0;
      dly_target_r      <= PC_RESET;
      pc_r              <= PC_RESET;
      return_link_reg_r <= 32'h0;
      t_flag_r          <= 1'b0;
      instr_ready_r     <= 1'b1;
      dma_block_r       <= 1'b0;
      ext_grant_r       <= 1'b0;
      bus_req_r         <= '0;
      for (int i = 0; i < 16; i++) begin
        rf_r[i] <= 32'h0;
      end
    end else begin
      st_r              <= st_nxt;
      cnt_r             <= cnt_nxt;
      ats_r             <= ats_nxt;
      op_r              <= op_nxt;
      dly_pend_r        <= dly_pend_nxt;
      dly_target_r      <= dly_target_nxt;
      pc_r              <= pc_nxt;
      return_link_reg_r <= link_nxt;
      t_flag_r          <= t_nxt;
      instr_ready_r     <= ready_nxt;
      dma_block_r       <= block_nxt;
      ext_grant_r       <= grant_nxt;
      bus_req_r         <= req_nxt;
      rf_r              <= rf_nxt;
    end
  end

  // ==========================================================
  // Checks
  sequence s_ats_go;
    acc && is_ats;
  endsequence
  sequence s_taken_stall;
    !instr_ready_r ##1 !instr_ready_r ##1 instr_ready_r;
  endsequence

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_minus_borrow: assert property (acc && is_sub_bor |=> t_flag_r == $past(borrow_w))
    else $error("borrow not loaded into flag");
  a_minus_ovf: assert property (acc && is_sub_ovf |=> t_flag_r == $past(ovf_w))
    else $error("underflow flag wrong");
  a_mask_test_flag: assert property (acc && is_mtest |=> t_flag_r == $past(and_zero_w))
    else $error("mask test flag wrong");
  a_mem_read_addr: assert property (acc && (is_mem_op || is_mem_mask)
    |=> bus_req_r.valid && !bus_req_r.write && bus_req_r.addr == $past(mem_addr_w))
    else $error("byte read not issued at indexed base");
  a_ats_lock: assert property (s_ats_go |=> dma_block_r [*2])
    else $error("transfer lock not held");
  a_ext_grant: assert property (st_r == ST_HOLD && ext_sync_r
    |=> ext_grant_r && !bus_req_r.valid)
    else $error("external request not granted");
  a_rotate_flag: assert property (acc && is_rot_l |=> t_flag_r == $past(rn_w[31]))
    else $error("rotate flag wrong");
  a_multi_keep_t: assert property (acc && is_multi |=> $stable(t_flag_r))
    else $error("multi-bit shift changed flag");
  a_taken_cycles: assert property (acc && is_bcc && taken_w && !dly_pend_r |=> s_taken_stall)
    else $error("taken branch not 3 cycles");
  a_slot_target: assert property (acc && dly_pend_r |=> pc_r == $past(dly_target_r))
    else $error("target not reached after slot");
  a_call_link: assert property (acc && is_rcall && !dly_pend_r
    |=> return_link_reg_r == $past(pc4_w))
    else $error("link register not saved");
endmodule // cse_exec

// file: tb/cse_bus_mem.sv
// Byte memory on the system bus, answering after a set number of wait cycles
`timescale 1ns/1ps
module cse_bus_mem (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire cse_pkg::cse_bus_req_type bus_req,
  input  wire logic                     dma_block,
  output cse_pkg::cse_bus_rsp_type      bus_rsp
);
  import cse_pkg::*;
  logic [7:0]  mem [0:1023];
  logic [31:0] last_addr;
  logic [7:0]  junk_r;
  int          wait_n = 0;
  int          blocked = 0;
  int          cnt_r;
  // ==========================================================
  // Ready after wait_n cycles; read data is junk outside a read answer
  always_comb begin
    bus_rsp.ready = bus_req.valid && (cnt_r >= wait_n);
    bus_rsp.rdata = (bus_rsp.ready && !bus_req.write) ? mem[bus_req.addr[9:0]] : junk_r;
  end
  always @(posedge clk_sys) begin
    junk_r <= rst_n ? ~junk_r + 8'h03 : 8'hA5;
    if (!rst_n || bus_rsp.ready) cnt_r <= 0;
    else if (bus_req.valid) cnt_r <= cnt_r + 1;
    if (rst_n && bus_rsp.ready) begin
      last_addr <= bus_req.addr;
      if (bus_req.write) mem[bus_req.addr[9:0]] <= bus_req.wdata;
      if (dma_block) blocked <= blocked + 1;
    end
  end
endmodule // cse_bus_mem

// file: tb/tb.sv
// Self-checking bench for the shift, logic and branch execute unit
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import cse_pkg::*;
  logic            clk_sys = 1'b0;
  logic            rst_n;
  logic            instr_valid;
  logic [15:0]     instr;
  logic            instr_ready_r;
  logic [31:0]     global_base_reg;
  logic            rf_load_en;
  logic [3:0]      rf_load_idx;
  logic [31:0]     rf_load_data;
  cse_bus_req_type bus_req_r;
  cse_bus_rsp_type bus_rsp;
  logic            dma_block_r;
  logic            external_bus_request;
  logic            ext_grant_r;
  logic            t_flag_r;
  logic [31:0]     pc_r;
  logic [31:0]     return_link_reg_r;
  int              mismatches = 0;
  int              compares = 0;
  int              cycles = 0;
  int              low;
  always #2.5 clk_sys = ~clk_sys;
  cse_exec dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .instr_ready_r(instr_ready_r),
    .global_base_reg(global_base_reg), .rf_load_en(rf_load_en), .rf_load_idx(rf_load_idx),
    .rf_load_data(rf_load_data), .bus_req_r(bus_req_r), .bus_rsp(bus_rsp), .dma_block_r(dma_block_r),
    .external_bus_request(external_bus_request), .ext_grant_r(ext_grant_r), .pc_r(pc_r), .t_flag_r(t_flag_r),
    .return_link_reg_r(return_link_reg_r)
  );
  cse_bus_mem far (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req_r), .dma_block(dma_block_r), .bus_rsp(bus_rsp)
  );
  // ==========================================================
  // Drivers
  task automatic close_out();
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(input logic [15:0] w);
    int n = 0;
    while (instr_ready_r !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
      low++;
    end
    instr_valid = 1'b1;
    instr = w;
    @(negedge clk_sys);
  endtask
  task automatic drain();
    int n = 0;
    instr_valid = 1'b0;
    while (instr_ready_r !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
      low++;
    end
    @(negedge clk_sys);
  endtask
  task automatic load(input logic [3:0] idx, input logic [31:0] d);
    rf_load_en = 1'b1;
    rf_load_idx = idx;
    rf_load_data = d;
    @(negedge clk_sys);
    rf_load_en = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic set_t(input logic b);
    issue(b ? 16'h2888 : 16'h2998);
  endtask
  task automatic rd0(input logic [31:0] exp);
    issue(16'hCC00);
    drain();
    `CHK(far.last_addr, exp + global_base_reg)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_arith();
    load(4'h0, 32'h7);
    load(4'h1, 32'h8);
    load(4'h2, 32'h1);
    set_t(1'b1);
    issue(16'h301A);
    drain();
    `CHK(t_flag_r, 1'b1)
    rd0(32'hFFFF_FFFE);
    load(4'h0, 32'h8000_0000);
    issue(16'h330B);
    drain();
    `CHK(t_flag_r, 1'b1)
    issue(16'h302B);
    drain();
    `CHK(t_flag_r, 1'b1)
    issue(16'h301B);
    drain();
    `CHK(t_flag_r, 1'b0)
    issue(16'h2018);
    drain();
    `CHK(t_flag_r, 1'b1)
    rd0(32'h7FFF_FFF7);
    issue(16'h2008);
    drain();
    `CHK(t_flag_r, 1'b0)
  endtask
  task automatic t_shift();
    logic [15:0] op [14] = '{16'h4004, 16'h4005, 16'h4024, 16'h4025, 16'h4020, 16'h4000, 16'h4021,
                             16'h4001, 16'h4008, 16'h4009, 16'h4018, 16'h4019, 16'h4028, 16'h4029};
    logic [31:0] ex [14] = '{32'h3, 32'h40000001, 32'h2, 32'hC0000001, 32'h2, 32'h2, 32'hC0000001,
                             32'h40000001, 32'h4, 32'h20000000, 32'h100, 32'h800000, 32'h10000, 32'h8000};
    logic [13:0] vs = 14'h00CA;
    logic [13:0] ti = 14'h2A08;
    logic [13:0] et = 14'h2A35;
    for (int i = 0; i < 14; i++) begin
      load(4'h0, vs[i] ? 32'h8000_0002 : 32'h8000_0001);
      set_t(ti[i]);
      issue(op[i]);
      drain();
      `CHK(t_flag_r, et[i])
      rd0(ex[i]);
    end
  endtask
  task automatic t_logic();
    load(4'h0, 32'h1234_5678);
    set_t(1'b1);
    issue(16'hC9F0);
    issue(16'hCB0F);
    issue(16'hCAFF);
    drain();
    `CHK(t_flag_r, 1'b1)
    rd0(32'h80);
    load(4'h0, 32'h20);
    far.mem[10'h120] = 8'h3C;
    far.wait_n = 2;
    issue(16'hCCC3);
    drain();
    `CHK(t_flag_r, 1'b1)
    issue(16'hCC0C);
    drain();
    `CHK(t_flag_r, 1'b0)
    issue(16'hCD0F);
    issue(16'hCF80);
    issue(16'hCEFF);
    drain();
    `CHK({t_flag_r, far.mem[10'h120]}, 9'h073)
    far.wait_n = 0;
  endtask
  task automatic t_atomic();
    int n = 0;
    load(4'hA, 32'h200);
    far.mem[10'h200] = 8'h00;
    issue(16'h4A1B);
    drain();
    `CHK({t_flag_r, far.mem[10'h200]}, 9'h180)
    `CHK(far.blocked, 2)
    external_bus_request = 1'b1;
    issue(16'h4A1B);
    while (ext_grant_r !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK({ext_grant_r, dma_block_r, bus_req_r.valid}, 3'b110)
    external_bus_request = 1'b0;
    drain();
    `CHK({t_flag_r, far.mem[10'h200]}, 9'h080)
    `CHK(far.blocked, 4)
  endtask
  task automatic br(input logic [15:0] op, input logic t, input int kind, input logic take, dl, call);
    logic [31:0] p;
    logic [31:0] tg;
    logic [31:0] lk;
    set_t(t);
    p = pc_r;
    lk = return_link_reg_r;
    case (kind)
      0: tg = p + 32'h4 + {{23{op[7]}}, op[7:0], 1'b0};
      1: tg = p + 32'h4 + {{19{op[11]}}, op[11:0], 1'b0};
      2: tg = p + 32'h4 + 32'h300;
      3: tg = 32'h300;
      default: tg = lk;
    endcase
    low = 0;
    issue(op);
    if (dl) issue(16'h2998);
    drain();
    `CHK(pc_r, take ? tg : p + (dl ? 32'h4 : 32'h2))
    `CHK(low, take ? (dl ? 1 : 2) : 0)
    `CHK(return_link_reg_r, call ? p + 32'h4 : lk)
    if (dl) `CHK(t_flag_r, 1'b0)
  endtask
  task automatic t_branch();
    load(4'hC, 32'h300);
    br(16'h89FC, 1'b1, 0, 1'b1, 1'b0, 1'b0);
    br(16'h89FC, 1'b0, 0, 1'b0, 1'b0, 1'b0);
    br(16'h8B10, 1'b0, 0, 1'b1, 1'b0, 1'b0);
    br(16'h8B10, 1'b1, 0, 1'b0, 1'b0, 1'b0);
    br(16'h8DF0, 1'b1, 0, 1'b1, 1'b1, 1'b0);
    br(16'h8DF0, 1'b0, 0, 1'b0, 1'b1, 1'b0);
    br(16'h8F7F, 1'b0, 0, 1'b1, 1'b1, 1'b0);
    br(16'h8F7F, 1'b1, 0, 1'b0, 1'b1, 1'b0);
    br(16'hA7FF, 1'b1, 1, 1'b1, 1'b1, 1'b0);
    br(16'hB800, 1'b1, 1, 1'b1, 1'b1, 1'b1);
    br(16'h0C23, 1'b1, 2, 1'b1, 1'b1, 1'b0);
    br(16'h0C03, 1'b1, 2, 1'b1, 1'b1, 1'b1);
    br(16'h4C0B, 1'b1, 3, 1'b1, 1'b1, 1'b1);
    br(16'h4C2B, 1'b1, 3, 1'b1, 1'b1, 1'b0);
    br(16'h000B, 1'b1, 4, 1'b1, 1'b1, 1'b0);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0009;
    global_base_reg = 32'h100;
    rf_load_en = 1'b0;
    rf_load_idx = 4'h0;
    rf_load_data = 32'h0;
    external_bus_request = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK({pc_r, t_flag_r, return_link_reg_r, instr_ready_r, bus_req_r.valid, dma_block_r, ext_grant_r}, 69'h8)
    load(4'h9, 32'h1);
    t_arith();
    t_shift();
    t_logic();
    t_atomic();
    t_branch();
    close_out();
  end
endmodule // tb
